// ### logic/psl_defines.vh
// Constants for the positioning stop, soft limit and program select block
`ifndef PSL_DEFINES_VH
`define PSL_DEFINES_VH
// APB register byte addresses
`define PSL_A_CTRL 8'h00
`define PSL_A_EZERO 8'h04
`define PSL_A_ULIM 8'h08
`define PSL_A_LLIM 8'h0C
`define PSL_A_PROGSEL 8'h10
`define PSL_A_XPROG 8'h14
`define PSL_A_YPROG 8'h18
`define PSL_A_XPOS 8'h1C
`define PSL_A_STATUS 8'h20
`define PSL_A_PROGNUM 8'h24
`define PSL_A_ERR 8'h28
// Control register fields
`define PSL_CTRL_STOPMODE 2:0
`define PSL_CTRL_RST 3'h0
// Program select register fields
`define PSL_PS_SRC 1:0
`define PSL_PS_HEADIN 7:2
`define PSL_PS_HEADOUT 13:8
`define PSL_PS_IVAL 20:14
`define PSL_PS_RST 21'h0C8000
// Program selection sources
`define PSL_SRC_FIXED 2'h0
`define PSL_SRC_ONE 2'h1
`define PSL_SRC_TWO 2'h2
`define PSL_SRC_REG 2'h3
// Instruction codes of interest
`define PSL_CODE_LIN 8'h01
`define PSL_CODE_CW 8'h02
`define PSL_CODE_CCW 8'h03
`define PSL_CODE_EZR 8'h30
`define PSL_CODE_INT 8'h31
`define PSL_CODE_IRQ1 8'h71
`define PSL_CODE_IRQ2 8'h72
// Aux end code and limit error code (BCD)
`define PSL_AUX_END 8'h02
`define PSL_ERR_LIMIT 16'h4004
// Zero address range
`define PSL_EZ_MAX 32'sd999999
`define PSL_EZ_MIN (-32'sd999999)
// Read interval range, ms
`define PSL_IVAL_MIN 7'h07
`define PSL_IVAL_MAX 7'h64
// Timing
`define PSL_CLK_HZ 40000000
`define PSL_MS_NS 1000000
`define PSL_CLK_NS 25
`define PSL_MS_CYC (`PSL_MS_NS / `PSL_CLK_NS)
`define PSL_SAMPLE_BACK 16'h0001
`endif

// ### logic/psl_positioning_ctrl.v
// Stop handling, software limits and program number selection logic
`timescale 1ns/1ps
`include "psl_defines.vh"

module psl_positioning_ctrl #(
  parameter NUM_IN = 64, // General input count
  parameter NUM_OUT = 64, // General output count
  parameter MS_CYCLES = `PSL_MS_CYC // Clock cycles per millisecond
) (
  input wire sys_clk, // System clock, 40 MHz
  input wire reset, // Synchronous reset, active high
  input wire [7:0] paddr, // APB address
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error
  input wire stopTerminal, // External stop input
  input wire xStopRelay, // X axis stop relay
  input wire yStopRelay, // Y axis stop relay
  input wire startCmd, // Start command pulse
  input wire selYAxis, // Program request is for Y axis
  input wire [7:0] instrCode, // Executing instruction code
  input wire instrRunning, // Positioning step active
  input wire jogFwd, // Jog forward request
  input wire jogRev, // Jog reverse request
  input wire zeroDone, // Zero return or abs detect done
  input wire auxWait, // Waiting for aux code off
  input wire [NUM_IN-1:0] genIn, // General inputs
  output reg [NUM_OUT-1:0] strobeOut, // Digit strobes
  output reg [6:0] programNum, // Selected program number
  output reg progValid, // Program number ready pulse
  output reg motionStop, // Stop motion now
  output reg holdTimer, // Freeze step timer
  output reg resumeRemain, // Start resumes remaining move
  output reg jumpNext, // Next-step jump pulse
  output reg jumpEnd, // Jump to end pulse
  output reg auxEndReplace, // Aux code swapped to end
  output reg [7:0] auxCode, // Pending aux code
  output reg [31:0] zeroTarget, // Target for zero return
  output reg limitError, // Soft limit error level
  output reg [15:0] errorCode, // Current error code
  output reg xPositionEstablishedFlag // Present value established
);

  // One-hot states of the digit reader
  localparam S_IDLE = 3'b001;
  localparam S_DIG0 = 3'b010;
  localparam S_DIG1 = 3'b100;

  // Register file
  reg [2:0] stopModeSetting_q; // Stop mode
  reg [31:0] electricalZeroAddress_q; // Zero point address
  reg [31:0] upperSoftLimit_q; // Upper soft limit
  reg [31:0] lowerSoftLimit_q; // Lower soft limit
  reg [20:0] progSel_q; // Source, heads, interval
  reg [6:0] xProgramNumberRegister_q; // X or both program
  reg [6:0] yProgramNumberRegister_q; // Y program
  reg [31:0] presentPos_q; // Present position value
  reg [7:0] auxCodeIn_q; // Aux code from host

  // Digit reader state
  reg [2:0] state_q;
  reg [6:0] msLeft_q; // Milliseconds left of strobe
  reg [31:0] cyc_q; // Cycles within current ms
  reg [3:0] tens_q; // First digit held
  reg stopSeen_q; // Stop edge detect

  wire [1:0] progSrc = progSel_q[`PSL_PS_SRC];
  wire [5:0] headIn = progSel_q[`PSL_PS_HEADIN];
  wire [5:0] headOut = progSel_q[`PSL_PS_HEADOUT];
  wire [6:0] ivalMs = progSel_q[`PSL_PS_IVAL];
  // Signed compare, the limits span the full 32-bit range
  wire signed [31:0] posS = presentPos_q;
  wire signed [31:0] upS = upperSoftLimit_q;
  wire signed [31:0] loS = lowerSoftLimit_q;

  // Stop request from any of the three sources
  wire stopReq = stopTerminal | xStopRelay | yStopRelay;
  // Rising edge only, so a held stop acts once
  wire stopRise = stopReq & ~stopSeen_q;

  // Interpolation and interrupt classes
  wire isInterp = (instrCode == `PSL_CODE_LIN) |
    (instrCode == `PSL_CODE_CW) | (instrCode == `PSL_CODE_CCW) |
    (instrCode == `PSL_CODE_INT);
  wire isIrq = (instrCode == `PSL_CODE_IRQ1) |
    (instrCode == `PSL_CODE_IRQ2);

  // Mode decoding
  wire modeIgnore = (stopModeSetting_q[1:0] == 2'h0);
  wire modeRemain = (stopModeSetting_q[1:0] == 2'h1);
  wire modeNext = (stopModeSetting_q[1:0] == 2'h2);
  wire modeEnd = (stopModeSetting_q[1:0] == 2'h3);
  // Mode 5/6 keep their behaviour while interpolating
  wire interpBreaks = isIrq | (isInterp & ~stopModeSetting_q[2]);

  // Limit check, armed only after position established
  wire limArm = xPositionEstablishedFlag & (upS > loS);
  wire overUp = limArm & (posS >= upS);
  wire underLo = limArm & (posS <= loS);
  wire limHit = overUp | underLo;
  // Jog back toward the valid range stays allowed
  wire jogAway = (overUp & jogRev & ~jogFwd) |
    (underLo & jogFwd & ~jogRev);

  // Zero address clamp
  // Clamped at write so readback shows the value in use
  wire signed [31:0] ezIn = pwdata;
  wire [31:0] ezClamp = (ezIn > `PSL_EZ_MAX) ? `PSL_EZ_MAX :
    (ezIn < `PSL_EZ_MIN) ? `PSL_EZ_MIN : pwdata;

  // Digit sampled from the head inputs, BCD 1,2,4,8
  wire [NUM_IN-1:0] inShift = genIn >> headIn;
  wire [3:0] digit = inShift[3:0];
  wire [NUM_OUT-1:0] strobe0 = {{(NUM_OUT-1){1'b0}}, 1'b1} << headOut;
  wire [NUM_OUT-1:0] strobe1 = strobe0 << 1;
  // Sample in the last cycle of the final ms of the strobe
  wire sampleNow = (msLeft_q == 7'h01) &&
    (cyc_q == MS_CYCLES - 1);
  // Interval is stored raw and clamped on use
  wire [6:0] ivalUse = (ivalMs < `PSL_IVAL_MIN) ? `PSL_IVAL_MIN :
    (ivalMs > `PSL_IVAL_MAX) ? `PSL_IVAL_MAX : ivalMs;
  // Tens weight of the first digit
  wire [6:0] tensVal = {3'h0, tens_q} * 7'h0A;

  // Write lands at the access edge, read latches at setup
  wire apbWr = psel & penable & pwrite;
  wire apbRd = psel & ~penable & ~pwrite;

  // Register writes
  always @(posedge sys_clk) begin
    if (reset) begin
      stopModeSetting_q <= `PSL_CTRL_RST;
      electricalZeroAddress_q <= 32'h0;
      upperSoftLimit_q <= 32'h0;
      lowerSoftLimit_q <= 32'h0;
      progSel_q <= `PSL_PS_RST;
      xProgramNumberRegister_q <= 7'h0;
      yProgramNumberRegister_q <= 7'h0;
      presentPos_q <= 32'h0;
      auxCodeIn_q <= 8'h0;
    end else if (apbWr) begin
      // Status, program number and error are read only
      case (paddr)
        `PSL_A_CTRL: begin
          stopModeSetting_q <= pwdata[`PSL_CTRL_STOPMODE];
          auxCodeIn_q <= pwdata[15:8];
        end
        `PSL_A_EZERO: electricalZeroAddress_q <= ezClamp;
        `PSL_A_ULIM: upperSoftLimit_q <= pwdata;
        `PSL_A_LLIM: lowerSoftLimit_q <= pwdata;
        `PSL_A_PROGSEL: progSel_q <= pwdata[20:0];
        `PSL_A_XPROG: xProgramNumberRegister_q <= pwdata[6:0];
        `PSL_A_YPROG: yProgramNumberRegister_q <= pwdata[6:0];
        `PSL_A_XPOS: presentPos_q <= pwdata;
        default: begin
          // Unmapped writes are dropped; only addresses above 0x28 get an error answer
        end
      endcase
    end
  end

  // APB answer: no wait states, read data latched in setup
  always @(posedge sys_clk) begin
    if (reset) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // Refusal is flagged in the same cycle as ready
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr > `PSL_A_ERR);
      if (apbRd) begin
        case (paddr)
          `PSL_A_CTRL: prdata <= {16'h0, auxCodeIn_q, 5'h0,
            stopModeSetting_q};
          `PSL_A_EZERO: prdata <= electricalZeroAddress_q;
          `PSL_A_ULIM: prdata <= upperSoftLimit_q;
          `PSL_A_LLIM: prdata <= lowerSoftLimit_q;
          `PSL_A_PROGSEL: prdata <= {11'h0, progSel_q};
          `PSL_A_XPROG: prdata <= {25'h0, xProgramNumberRegister_q};
          `PSL_A_YPROG: prdata <= {25'h0, yProgramNumberRegister_q};
          `PSL_A_XPOS: prdata <= presentPos_q;
          `PSL_A_STATUS: prdata <= {26'h0, state_q, holdTimer,
            limitError, xPositionEstablishedFlag};
          `PSL_A_PROGNUM: prdata <= {25'h0, programNum};
          `PSL_A_ERR: prdata <= {16'h0, errorCode};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  // Stop handling and aux code
  always @(posedge sys_clk) begin
    if (reset) begin
      stopSeen_q <= 1'b0;
      holdTimer <= 1'b0;
      resumeRemain <= 1'b0;
      jumpNext <= 1'b0;
      jumpEnd <= 1'b0;
      auxEndReplace <= 1'b0;
      auxCode <= 8'h0;
      motionStop <= 1'b0;
      zeroTarget <= 32'h0;
    end else begin
      // Stop level kept for the edge detector
      stopSeen_q <= stopReq;
      // Jump and swap outputs last one cycle
      jumpNext <= 1'b0;
      jumpEnd <= 1'b0;
      auxEndReplace <= 1'b0;
      // Zero return always aims at the stored address
      zeroTarget <= electricalZeroAddress_q;
      if (instrCode == `PSL_CODE_EZR && instrRunning)
        zeroTarget <= electricalZeroAddress_q;
      // Limit halts at once unless jogging away from it
      motionStop <= (limHit & ~jogAway) |
        (stopReq & ~modeIgnore & instrRunning);
      // Aux code tracks host only while no aux wait is pending
      if (!auxWait)
        auxCode <= auxCodeIn_q;
      if (stopRise && instrRunning && !modeIgnore) begin
        // Mode 0/4 leaves all unchanged, including aux code
        holdTimer <= 1'b1;
        if (interpBreaks && (modeRemain || modeNext)) begin
          jumpEnd <= 1'b1;
        end else if (modeRemain) begin
          resumeRemain <= 1'b1;
        end else if (modeNext) begin
          resumeRemain <= 1'b0;
        end else if (modeEnd) begin
          jumpEnd <= 1'b1;
          resumeRemain <= 1'b0;
        end
        // Aux-active is left alone; host must clear it
        if (modeEnd && auxWait) begin
          auxCode <= `PSL_AUX_END;
          auxEndReplace <= 1'b1;
        end
      end else if (startCmd && holdTimer) begin
        holdTimer <= 1'b0;
        // Discarded remainder becomes a jump to next step
        jumpNext <= ~resumeRemain & modeNext;
        resumeRemain <= 1'b0;
      end
    end
  end

  // Position established flag and limit error
  always @(posedge sys_clk) begin
    if (reset) begin
      xPositionEstablishedFlag <= 1'b0;
      limitError <= 1'b0;
      errorCode <= 16'h0;
    end else begin
      // Sticky until reset; software cannot clear it
      if (zeroDone)
        xPositionEstablishedFlag <= 1'b1;
      // Error follows position; clears once back inside
      limitError <= limHit;
      errorCode <= limHit ? `PSL_ERR_LIMIT : 16'h0;
    end
  end

  // Program number selection and digit reading
  always @(posedge sys_clk) begin
    if (reset) begin
      state_q <= S_IDLE;
      msLeft_q <= 7'h0;
      cyc_q <= 32'h0;
      tens_q <= 4'h0;
      strobeOut <= {NUM_OUT{1'b0}};
      programNum <= 7'h0;
      progValid <= 1'b0;
    end else begin
      // Valid is a one-cycle pulse
      progValid <= 1'b0;
      // Millisecond timer runs only while a strobe is on
      if (state_q != S_IDLE) begin
        if (cyc_q == MS_CYCLES - 1) begin
          cyc_q <= 32'h0;
          msLeft_q <= msLeft_q - 7'h01;
        end else begin
          cyc_q <= cyc_q + 32'h1;
        end
      end
      // A start during a read is ignored
      case (state_q)
        S_IDLE: begin
          strobeOut <= {NUM_OUT{1'b0}};
          if (startCmd) begin
            case (progSrc)
              `PSL_SRC_FIXED: begin
                programNum <= 7'h0;
                progValid <= 1'b1;
              end
              `PSL_SRC_REG: begin
                programNum <= selYAxis ? yProgramNumberRegister_q :
                  xProgramNumberRegister_q;
                progValid <= 1'b1;
              end
              default: begin
                // Switch read runs on a start taken in idle with source one or two digits
                state_q <= S_DIG0;
                msLeft_q <= ivalUse;
                cyc_q <= 32'h0;
                strobeOut <= strobe0;
              end
            endcase
          end
        end
        S_DIG0: begin
          if (sampleNow) begin
            if (progSrc == `PSL_SRC_ONE) begin
              // Non-BCD digit reads as zero
              programNum <= (digit > 4'h9) ? 7'h0 :
                {3'h0, digit};
              progValid <= 1'b1;
              strobeOut <= {NUM_OUT{1'b0}};
              state_q <= S_IDLE;
            end else begin
              tens_q <= (digit > 4'h9) ? 4'h0 : digit;
              state_q <= S_DIG1;
              msLeft_q <= ivalUse;
              strobeOut <= strobe1;
            end
          end
        end
        S_DIG1: begin
          // Second strobe carries the units digit
          if (sampleNow) begin
            programNum <= tensVal + ((digit > 4'h9) ? 7'h0 :
              {3'h0, digit});
            progValid <= 1'b1;
            strobeOut <= {NUM_OUT{1'b0}};
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

endmodule

// ### test/psl_switch_model.sv
// Thumbwheel digit switches behind the strobe outputs
`timescale 1ns/1ps
module psl_switch_model #(
  parameter NUM_IN = 64, // General input count
  parameter NUM_OUT = 64 // General output count
) (
  input wire sys_clk, // System clock
  input wire [NUM_OUT-1:0] strobeOut, // Digit strobes
  input wire [5:0] headIn, // First digit input
  input wire [5:0] headOut, // First strobe output
  input wire [3:0] dig0, // Digit behind first strobe
  input wire [3:0] dig1, // Digit behind second strobe
  output reg [NUM_IN-1:0] genIn // Switch lines
);
  initial genIn = {NUM_IN{1'b0}};
  // Unselected lines toggle so stale data never looks valid
  always @(posedge sys_clk) begin
    genIn <= ~genIn;
    if (strobeOut[headOut] === 1'b1) begin
      genIn[headIn +: 4] <= dig0;
    end else if (strobeOut[headOut + 6'h01] === 1'b1) begin
      genIn[headIn +: 4] <= dig1;
    end
  end
endmodule

// ### test/psl_ctrl_checker.sv
// Port-level checks for the positioning control block
`timescale 1ns/1ps
module psl_ctrl_checker #(
  parameter NUM_OUT = 64 // Strobe count
) (
  input wire sys_clk, // Clock
  input wire reset, // Sync reset
  input wire [7:0] paddr, // APB address
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pready, // APB ready
  input wire pslverr, // APB error
  input wire startCmd, // Start
  input wire zeroDone, // Zero return done
  input wire jogFwd, // Jog forward
  input wire jogRev, // Jog reverse
  input wire [NUM_OUT-1:0] strobeOut, // Strobes
  input wire [6:0] programNum, // Program number
  input wire progValid, // Program ready
  input wire holdTimer, // Timer frozen
  input wire jumpNext, // Next jump
  input wire motionStop, // Stop motion
  input wire limitError, // Limit error
  input wire [15:0] errorCode, // Error code
  input wire xPositionEstablishedFlag // Position established
);
  // Single clock domain, reset masks every check
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_apb_no_wait:
    assert property (psel && !penable ##1 psel && penable |-> pready)
    else $error("access phase without ready");
  a_ready_one:
    assert property (pready |=> !pready) else $error("ready too long");
  a_refuse_high:
    assert property (pready && paddr > 8'h28 |-> pslverr)
    else $error("unmapped access not refused");
  a_err_code:
    assert property (errorCode == (limitError ? 16'h4004 : 16'h0000))
    else $error("error code mismatch");
  a_armed_first:
    assert property (!xPositionEstablishedFlag |-> !limitError)
    else $error("limit checked before zero");
  a_flag_sets:
    assert property (zeroDone |=> xPositionEstablishedFlag)
    else $error("flag not set");
  a_flag_sticky:
    assert property ($past(xPositionEstablishedFlag) |->
      xPositionEstablishedFlag) else $error("flag dropped");
  a_hold_stands:
    assert property (holdTimer && !startCmd |=> holdTimer)
    else $error("timer hold lost");
  a_hold_clears:
    assert property (holdTimer && startCmd |=> !holdTimer)
    else $error("timer hold stuck");
  a_strobe_turns:
    assert property ($onehot0(strobeOut)) else $error("strobes overlap");
  a_prog_range:
    assert property (progValid |-> programNum <= 7'd99)
    else $error("program number out of range");
  a_next_pulse:
    assert property (jumpNext |=> !jumpNext) else $error("jump too long");
  a_limit_halts:
    assert property ($rose(limitError) && !jogFwd && !jogRev |-> ##[0:1]
      motionStop) else $error("limit did not stop");
endmodule
bind psl_positioning_ctrl psl_ctrl_checker #(.NUM_OUT(NUM_OUT)) chk (
  .sys_clk(sys_clk), .reset(reset), .paddr(paddr), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr),
  .startCmd(startCmd), .zeroDone(zeroDone), .jogFwd(jogFwd),
  .jogRev(jogRev), .strobeOut(strobeOut), .programNum(programNum),
  .progValid(progValid), .holdTimer(holdTimer), .jumpNext(jumpNext),
  .motionStop(motionStop), .limitError(limitError),
  .errorCode(errorCode),
  .xPositionEstablishedFlag(xPositionEstablishedFlag));

// ### test/tb.sv
// Self-checking bench for the positioning control block
`timescale 1ns/1ps
`include "psl_defines.vh"
module tb;
  reg sys_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0;
  reg pwrite = 1'b0, stopTerminal = 1'b0, xStopRelay = 1'b0;
  reg yStopRelay = 1'b0, startCmd = 1'b0, selYAxis = 1'b0;
  reg instrRunning = 1'b0, jogFwd = 1'b0, jogRev = 1'b0;
  reg zeroDone = 1'b0, auxWait = 1'b0, slv;
  reg [7:0] paddr = 8'h00, instrCode = 8'h00, hAux;
  reg [31:0] pwdata = 32'h00000000, rd;
  reg [5:0] headIn = 6'h06, headOut = 6'h03; // Odd offsets on purpose
  reg [3:0] dig0 = 4'h0, dig1 = 4'h0; // Switch settings
  reg [6:0] ivSel = 7'h07; // Read interval written by getProg
  wire [63:0] genIn, strobeOut;
  wire [31:0] prdata, zeroTarget;
  wire [15:0] errorCode;
  wire [7:0] auxCode;
  wire [6:0] programNum;
  wire pready, pslverr, progValid, motionStop, holdTimer, resumeRemain;
  wire jumpNext, jumpEnd, auxEndReplace, limitError, posFlag;
  integer errCount = 0, testsRun = 0, cyc = 0, nNext = 0, nEnd = 0;
  integer nAux = 0, wA = 0, wB = 0, dA, dE, dN, w0, w1, i;
  reg hHold, hRes, hMot;
  psl_positioning_ctrl #(.MS_CYCLES(4)) DUT (
    .sys_clk(sys_clk), .reset(reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stopTerminal(stopTerminal),
    .xStopRelay(xStopRelay), .yStopRelay(yStopRelay), .startCmd(startCmd),
    .selYAxis(selYAxis), .instrCode(instrCode), .instrRunning(instrRunning),
    .jogFwd(jogFwd), .jogRev(jogRev), .zeroDone(zeroDone),
    .auxWait(auxWait), .genIn(genIn), .strobeOut(strobeOut),
    .programNum(programNum), .progValid(progValid),
    .motionStop(motionStop), .holdTimer(holdTimer),
    .resumeRemain(resumeRemain), .jumpNext(jumpNext), .jumpEnd(jumpEnd),
    .auxEndReplace(auxEndReplace), .auxCode(auxCode),
    .zeroTarget(zeroTarget), .limitError(limitError),
    .errorCode(errorCode), .xPositionEstablishedFlag(posFlag));
  psl_switch_model SW (.sys_clk(sys_clk), .strobeOut(strobeOut),
    .headIn(headIn), .headOut(headOut), .dig0(dig0), .dig1(dig1),
    .genIn(genIn));
  // 40 MHz clock
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Pulse and strobe-width tallies; a hang ends the run
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    nNext <= nNext + jumpNext;
    nEnd <= nEnd + jumpEnd;
    nAux <= nAux + auxEndReplace;
    if (strobeOut[headOut] === 1'b1) wA <= wA + 1;
    if (strobeOut[headOut + 6'h01] === 1'b1) wB <= wB + 1;
    if (cyc == 20000) begin
      errCount = errCount + 1;
      results;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      testsRun = testsRun + 1;
      if (got !== exp) begin
        errCount = errCount + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  // One APB transfer; waits for ready, no fixed latency assumed
  task apb(input [7:0] a, input w, input [31:0] d);
    begin
      @(posedge sys_clk);
      psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0; penable <= 1'b0;
    end
  endtask
  task waitN(input integer k);
    repeat (k) @(posedge sys_clk);
  endtask
  task startPulse;
    begin
      @(posedge sys_clk) startCmd <= 1'b1;
      @(posedge sys_clk) startCmd <= 1'b0;
    end
  endtask
  // Stop in mode m from source s, then restart; record what came out
  task stopRun(input [2:0] m, input [7:0] code, input integer s);
    integer a0, e0, x0;
    begin
      apb(`PSL_A_CTRL, 1'b1, {16'h0000, 8'h15, 5'h00, m});
      // Aux wait held over the stop so the end-code swap can act
      @(posedge sys_clk) begin
        instrCode <= code; instrRunning <= 1'b1; auxWait <= 1'b1;
      end
      a0 = nAux; e0 = nEnd; x0 = nNext;
      @(posedge sys_clk) begin
        stopTerminal <= (s == 0); xStopRelay <= (s == 1);
        yStopRelay <= (s == 2);
      end
      waitN(3);
      hHold = holdTimer; hRes = resumeRemain; hMot = motionStop;
      hAux = auxCode;
      stopTerminal <= 1'b0; xStopRelay <= 1'b0; yStopRelay <= 1'b0;
      instrRunning <= 1'b0;
      auxWait <= 1'b0;
      startPulse;
      waitN(3);
      dA = nAux - a0; dE = nEnd - e0; dN = nNext - x0;
    end
  endtask
  task scnRegs;
    begin
      apb(8'h2C, 1'b0, 32'h00000000);
      chk(slv, 1); chk(rd, 0);
      apb(`PSL_A_EZERO, 1'b1, 32'd2000000);
      apb(`PSL_A_EZERO, 1'b0, 32'h00000000);
      chk(rd, 32'd999999);
      chk(zeroTarget, 32'd999999);
      apb(`PSL_A_EZERO, 1'b1, -32'sd1000000);
      apb(`PSL_A_EZERO, 1'b0, 32'h00000000);
      chk(rd, -32'sd999999);
      // Interval reads back raw; the strobe width shows the clamp
      ivSel = 7'd3;
      getProg(2'h1, 7'd0);
      chk(wA - w0, 28);
      apb(`PSL_A_PROGSEL, 1'b0, 32'h00000000);
      chk(rd[20:14], 3);
      ivSel = 7'd101;
      getProg(2'h1, 7'd0);
      chk(wA - w0, 400);
      apb(`PSL_A_PROGSEL, 1'b0, 32'h00000000);
      chk(rd[20:14], 101);
      ivSel = 7'd7;
      apb(`PSL_A_PROGSEL, 1'b1, 32'h00000000);
    end
  endtask
  task scnStop;
    for (i = 0; i < 8; i = i + 1) begin
      stopRun(i, 8'h10, i % 3);
      chk(hHold, i % 4 != 0);
      chk(hMot, i % 4 != 0);
      chk(hRes, i % 4 == 1);
      chk(hAux, (i % 4 == 3) ? 8'h02 : 8'h15);
      chk(dA, i % 4 == 3);
      chk(dN, i % 4 == 2);
      chk(dE, i % 4 == 3);
      chk(holdTimer, 0);
    end
  endtask
  // Interpolation and interrupt codes under modes 1 and 5
  task scnInterp;
    reg [47:0] tbl;
    begin
      tbl = 48'h010203317172;
      for (i = 0; i < 6; i = i + 1) begin
        stopRun(3'd1, tbl[47 - 8 * i -: 8], 0);
        chk(dE, 1);
        stopRun(3'd5, tbl[47 - 8 * i -: 8], 1);
        chk(dE, i > 3);
        chk(hRes, i < 4);
      end
    end
  endtask
  task getProg(input [1:0] s, input [6:0] exp);
    begin
      apb(`PSL_A_PROGSEL, 1'b1, {11'h000, ivSel, headOut, headIn, s});
      w0 = wA; w1 = wB;
      startPulse;
      @(posedge sys_clk);
      while (progValid !== 1'b1) @(posedge sys_clk);
      chk(programNum, exp);
    end
  endtask
  task scnProg;
    begin
      getProg(2'h0, 7'd0);
      apb(`PSL_A_XPROG, 1'b1, 32'd37);
      apb(`PSL_A_YPROG, 1'b1, 32'd58);
      getProg(2'h3, 7'd37);
      selYAxis <= 1'b1;
      getProg(2'h3, 7'd58);
      chk(wA - w0, 0);
      dig0 <= 4'h9;
      getProg(2'h1, 7'd9);
      chk(wA - w0, 28);
      chk(wB - w1, 0);
      dig0 <= 4'h9; dig1 <= 4'h3;
      getProg(2'h2, 7'd93);
      chk(wB - w1, 28);
    end
  endtask
  task posSet(input [31:0] p);
    begin
      apb(`PSL_A_XPOS, 1'b1, p);
      waitN(2);
    end
  endtask
  task scnLimit;
    begin
      apb(`PSL_A_ULIM, 1'b1, 32'd1000);
      apb(`PSL_A_LLIM, 1'b1, -32'sd1000);
      posSet(32'd1000);
      chk(limitError, 0);
      @(posedge sys_clk) zeroDone <= 1'b1;
      @(posedge sys_clk) zeroDone <= 1'b0;
      waitN(2);
      chk(posFlag, 1);
      chk(limitError, 1);
      chk(errorCode, 16'h4004);
      chk(motionStop, 1);
      @(posedge sys_clk) jogRev <= 1'b1;
      waitN(2);
      chk(motionStop, 0);
      jogRev <= 1'b0;
      posSet(32'd999);
      chk(limitError, 0);
      posSet(-32'sd1000);
      chk(limitError, 1);
      apb(`PSL_A_ULIM, 1'b1, -32'sd1000);
      posSet(32'd5000);
      chk(limitError, 0);
    end
  endtask
  task results;
    begin
      if (errCount == 0 && testsRun > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    scnRegs;
    scnStop;
    scnInterp;
    scnProg;
    scnLimit;
    results;
  end
endmodule
